// ### design/pim_mask_bank.sv
/*
 * Interrupt mask bank of the power-management device: four mask registers,
 * raw status synchronisers, edge detection, sticky flags and one interrupt line.
 * Assumes the serial host decoder drives reg_req on clk_sys, the otp controller
 * holds its defaults steady during rst, and raw levels come straight from analog.
 */
`include "pim_params.svh"

module pim_mask_bank
    import pim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic otp_valid,
    input wire pim_otp_t otp_defaults,
    input wire pim_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire pim_event_t events,
    input wire pim_raw_t raw_in,
    input wire pim_flag_t flag_clr,
    output pim_raw_t raw_status,
    output pim_flag_t flags,
    output logic irq
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // mask registers
    // ----------------------------------------
    logic [7:0] top_mask_one_q, top_mask_one_d;
    logic [7:0] top_mask_two_q, top_mask_two_d;
    logic [7:0] conv_mask_q, conv_mask_d;
    logic [7:0] stepup_mask_q, stepup_mask_d;
    logic [7:0] rdata_q, rdata_d;

    always_comb begin
        top_mask_one_d = top_mask_one_q;
        top_mask_two_d = top_mask_two_q;
        conv_mask_d = conv_mask_q;
        stepup_mask_d = stepup_mask_q;
        // reserved bits are plain storage, read back as written
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                `PIM_TOP_MASK_ONE_OFS: top_mask_one_d = reg_req.wdata;
                `PIM_TOP_MASK_TWO_OFS: top_mask_two_d = reg_req.wdata;
                `PIM_CONV_MASK_OFS: conv_mask_d = reg_req.wdata;
                `PIM_STEPUP_MASK_OFS: stepup_mask_d = reg_req.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_d = rdata_q;
        if (reg_req.rd_en) begin
            case (reg_req.addr)
                `PIM_TOP_MASK_ONE_OFS: rdata_d = top_mask_one_q;
                `PIM_TOP_MASK_TWO_OFS: rdata_d = top_mask_two_q;
                `PIM_CONV_MASK_OFS: rdata_d = conv_mask_q;
                `PIM_STEPUP_MASK_OFS: rdata_d = stepup_mask_q;
                default: rdata_d = `PIM_UNMAPPED_RDATA;
            endcase
        end
    end

    // reset is synchronous, so sampling the otp port here is safe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            if (otp_valid) begin
                top_mask_one_q <= otp_defaults.top_event_mask_one;
                top_mask_two_q <= otp_defaults.top_event_mask_two;
                conv_mask_q <= otp_defaults.converter_event_mask;
                stepup_mask_q <= otp_defaults.boost_event_mask;
            end else begin
                top_mask_one_q <= `PIM_TOP_MASK_ONE_RST;
                top_mask_two_q <= `PIM_TOP_MASK_TWO_RST;
                conv_mask_q <= `PIM_CONV_MASK_RST;
                stepup_mask_q <= `PIM_STEPUP_MASK_RST;
            end
        end else begin
            top_mask_one_q <= top_mask_one_d;
            top_mask_two_q <= top_mask_two_d;
            conv_mask_q <= conv_mask_d;
            stepup_mask_q <= stepup_mask_d;
        end
    end

    // read data kept in its own group so it never depends on otp sampling
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_q <= `PIM_UNMAPPED_RDATA;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // raw status synchronisers
    // ----------------------------------------
    pim_raw_t meta_q, meta_d;
    pim_raw_t sync_q, sync_d;
    pim_raw_t prev_q, prev_d;

    always_comb begin
        meta_d = raw_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // raw levels never pass through a mask
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ----------------------------------------
    // edge detection and masking
    // ----------------------------------------
    logic thermal_rise;
    logic conv1_pg_rise, conv1_pg_fall, conv1_curlim_rise;
    logic conv0_pg_rise, conv0_pg_fall, conv0_curlim_rise;
    logic stepup_pg_rise, stepup_pg_fall, stepup_curlim_rise;
    pim_flag_t set_v;

    always_comb begin
        thermal_rise = sync_q.thermal_warning & ~prev_q.thermal_warning;
        conv1_pg_rise = sync_q.conv1_pg & ~prev_q.conv1_pg;
        conv1_pg_fall = ~sync_q.conv1_pg & prev_q.conv1_pg;
        conv1_curlim_rise = sync_q.conv1_curlim & ~prev_q.conv1_curlim;
        conv0_pg_rise = sync_q.conv0_pg & ~prev_q.conv0_pg;
        conv0_pg_fall = ~sync_q.conv0_pg & prev_q.conv0_pg;
        conv0_curlim_rise = sync_q.conv0_curlim & ~prev_q.conv0_curlim;
        stepup_pg_rise = sync_q.stepup_pg & ~prev_q.stepup_pg;
        stepup_pg_fall = ~sync_q.stepup_pg & prev_q.stepup_pg;
        stepup_curlim_rise = sync_q.stepup_curlim & ~prev_q.stepup_curlim;

        set_v = '0;
        set_v.load_meas_ready_flag = events.load_meas_ready
            & ~top_mask_one_q[`PIM_LOAD_MEAS_READY_MASK_BIT];
        set_v.sync_clk_flag = events.sync_clk_detect
            & ~top_mask_one_q[`PIM_SYNC_CLK_MASK_BIT];
        set_v.thermal_warning_flag = thermal_rise
            & ~top_mask_one_q[`PIM_THERMAL_WARNING_MASK_BIT];
        set_v.reg_reset_flag = events.reg_reset
            & ~top_mask_two_q[`PIM_REG_RESET_MASK_BIT];
        // both transitions share one flag, each gated by its own bit
        set_v.conv1_pg_flag =
            (conv1_pg_fall & ~conv_mask_q[`PIM_CONV1_PG_FALL_MASK_BIT])
            | (conv1_pg_rise & ~conv_mask_q[`PIM_CONV1_PG_RISE_MASK_BIT]);
        set_v.conv1_curlim_flag = conv1_curlim_rise
            & ~conv_mask_q[`PIM_CONV1_CURLIM_MASK_BIT];
        set_v.conv0_pg_flag =
            (conv0_pg_fall & ~conv_mask_q[`PIM_CONV0_PG_FALL_MASK_BIT])
            | (conv0_pg_rise & ~conv_mask_q[`PIM_CONV0_PG_RISE_MASK_BIT]);
        set_v.conv0_curlim_flag = conv0_curlim_rise
            & ~conv_mask_q[`PIM_CONV0_CURLIM_MASK_BIT];
        set_v.stepup_pg_flag =
            (stepup_pg_fall & ~stepup_mask_q[`PIM_STEPUP_PG_FALL_MASK_BIT])
            | (stepup_pg_rise & ~stepup_mask_q[`PIM_STEPUP_PG_RISE_MASK_BIT]);
        set_v.stepup_curlim_flag = stepup_curlim_rise
            & ~stepup_mask_q[`PIM_STEPUP_CURLIM_MASK_BIT];
    end

    // ----------------------------------------
    // sticky flags and interrupt line
    // ----------------------------------------
    pim_flag_t flags_q, flags_d;
    logic irq_q, irq_d;

    // a set in the clearing cycle wins, so no event is lost
    always_comb begin
        flags_d = (flags_q & ~flag_clr) | set_v;
        irq_d = |flags_d;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags_q <= '0;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            irq_q <= irq_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign raw_status = sync_q;
    assign flags = flags_q;
    assign irq = irq_q;

endmodule

// ### design/pim_params.svh
/*
 * Holds the register offsets, documented reset values and mask bit positions
 * of the interrupt mask bank.
 * Assumes it is included by its bare name, once or more, by the package and the design.
 */
`ifndef PIM_PARAMS_SVH
`define PIM_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PIM_TOP_MASK_ONE_OFS 8'h29
`define PIM_TOP_MASK_TWO_OFS 8'h2A
`define PIM_CONV_MASK_OFS 8'h2B
`define PIM_STEPUP_MASK_OFS 8'h2C

// ----------------------------------------
// documented reset values
// ----------------------------------------
`define PIM_TOP_MASK_ONE_RST 8'h00
`define PIM_TOP_MASK_TWO_RST 8'h01
`define PIM_CONV_MASK_RST 8'h00
`define PIM_STEPUP_MASK_RST 8'h00
`define PIM_UNMAPPED_RDATA 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define PIM_LOAD_MEAS_READY_MASK_BIT 7
`define PIM_SYNC_CLK_MASK_BIT 3
`define PIM_THERMAL_WARNING_MASK_BIT 1
`define PIM_REG_RESET_MASK_BIT 0
`define PIM_CONV1_PG_FALL_MASK_BIT 7
`define PIM_CONV1_PG_RISE_MASK_BIT 6
`define PIM_CONV1_CURLIM_MASK_BIT 4
`define PIM_CONV0_PG_FALL_MASK_BIT 3
`define PIM_CONV0_PG_RISE_MASK_BIT 2
`define PIM_CONV0_CURLIM_MASK_BIT 0
`define PIM_STEPUP_PG_FALL_MASK_BIT 3
`define PIM_STEPUP_PG_RISE_MASK_BIT 2
`define PIM_STEPUP_CURLIM_MASK_BIT 0

`endif

// ### design/pim_pkg.sv
/*
 * Types of the interrupt mask bank: event pulses, raw status levels, flags
 * and the register access request.
 * Assumes pim_params.svh sits beside it.
 */
`include "pim_params.svh"

package pim_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // one-cycle events from logic on clk_sys
    // ----------------------------------------
    typedef struct packed {
        logic load_meas_ready;
        logic sync_clk_detect;
        logic reg_reset;
    } pim_event_t;

    // ----------------------------------------
    // raw analog status levels, not synchronous
    // ----------------------------------------
    typedef struct packed {
        logic thermal_warning;
        logic conv1_pg;
        logic conv1_curlim;
        logic conv0_pg;
        logic conv0_curlim;
        logic stepup_pg;
        logic stepup_curlim;
    } pim_raw_t;

    // ----------------------------------------
    // sticky interrupt flags
    // ----------------------------------------
    typedef struct packed {
        logic load_meas_ready_flag;
        logic sync_clk_flag;
        logic thermal_warning_flag;
        logic reg_reset_flag;
        logic conv1_pg_flag;
        logic conv1_curlim_flag;
        logic conv0_pg_flag;
        logic conv0_curlim_flag;
        logic stepup_pg_flag;
        logic stepup_curlim_flag;
    } pim_flag_t;

    // ----------------------------------------
    // register access from the serial host port
    // ----------------------------------------
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pim_reg_req_t;

    // ----------------------------------------
    // defaults delivered by the otp memory
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] top_event_mask_one;
        logic [7:0] top_event_mask_two;
        logic [7:0] converter_event_mask;
        logic [7:0] boost_event_mask;
    } pim_otp_t;

endpackage

// ### bench/pim_host_model.sv
/*
 * Host side of the mask bank: byte writes and reads on the register port.
 * Assumes clk_sys comes from the bench and pim_pkg is compiled first.
 */
module pim_host_model
    import pim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output pim_reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 100ps;
    initial reg_req = '0;
    // released lines show the inverse, never a stale address
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1 reg_req = '{1'b1, 1'b0, a, d};
        @(posedge clk_sys) #1 reg_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys) #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) #1 reg_req = '{1'b0, 1'b0, ~a, 8'hFF};
        d = reg_rdata;
    endtask
endmodule

// ### bench/pim_mask_bank_sva.sv
/*
 * Port checker of the mask bank.
 * Assumes one clock domain and the bind below.
 */
module pim_mask_bank_sva
    import pim_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire pim_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire pim_event_t events,
    input wire pim_raw_t raw_in,
    input wire pim_flag_t flag_clr,
    input wire pim_raw_t raw_status,
    input wire pim_flag_t flags,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // write, one cycle without a write, then a read of the same register
    sequence s_wr_idle_rd;
        (reg_req.wr_en && reg_req.addr inside {[8'h29:8'h2C]}) ##1 (!reg_req.wr_en)
            ##1 (reg_req.rd_en && !reg_req.wr_en && reg_req.addr == $past(reg_req.addr, 2));
    endsequence
    property p_rw;
        s_wr_idle_rd |=> reg_rdata == $past(reg_req.wdata, 3);
    endproperty
    rw_back_a: assert property (p_rw)
        else $error("read back differs from write");
    irq_any_a: assert property (irq == (flags != '0))
        else $error("irq is not the or of flags");
    raw_sync_a: assert property (!$past(rst) && !$past(rst, 2) |->
        raw_status == $past(raw_in, 2)) else $error("raw status lost its input");
    clr_wins_a: assert property (flags.reg_reset_flag && flag_clr.reg_reset_flag
        && !events.reg_reset |=> !flags.reg_reset_flag) else $error("flag not cleared");
    flag_sticky_a: assert property (1'b1 |=>
        ((~flags) & $past(flags & ~flag_clr)) == '0) else $error("flag dropped");
    rr_cause_a: assert property ($rose(flags.reg_reset_flag) |->
        $past(events.reg_reset)) else $error("reset flag without event");
    lm_cause_a: assert property ($rose(flags.load_meas_ready_flag) |->
        $past(events.load_meas_ready)) else $error("ready flag without event");
    pg_cause_a: assert property ($rose(flags.conv1_pg_flag) |->
        $past(raw_status.conv1_pg) != $past(raw_status.conv1_pg, 2))
        else $error("power good flag without transition");
    cl_cause_a: assert property ($rose(flags.conv0_curlim_flag) |->
        $past(raw_status.conv0_curlim) && !$past(raw_status.conv0_curlim, 2))
        else $error("current limit flag without rise");
endmodule

bind pim_mask_bank pim_mask_bank_sva u_sva (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .events(events), .raw_in(raw_in), .flag_clr(flag_clr),
    .raw_status(raw_status), .flags(flags), .irq(irq));

// ### bench/pim_mask_bank_test.sv
/*
 * Self-checking bench of the interrupt mask bank.
 * Assumes the design, the host model and the checker are compiled before it.
 */
module pim_mask_bank_test import pim_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // {event bit, flag bit, address, mask bit}
    localparam logic [19:0] EVT [3] = '{20'h29297, 20'h18293, 20'h062A0};
    // {raw bit, flag bit, address, mask, level, flag expected}
    localparam logic [31:0] RAW [28] = '{
        32'h67290210, 32'h67290000, 32'h67290011, 32'h67290000,
        32'h552B4010, 32'h552B4001, 32'h552B8011, 32'h552B8000,
        32'h442B1010, 32'h442B0000, 32'h442B2211, 32'h442B0000,
        32'h332B0410, 32'h332B0401, 32'h332B0811, 32'h332B0800,
        32'h222B0110, 32'h222B0000, 32'h222B2211, 32'h222B0000,
        32'h112C0410, 32'h112C0401, 32'h112C0811, 32'h112C0800,
        32'h002C0110, 32'h002C0000, 32'h002CF211, 32'h002C0000};
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic otp_valid = 1'b0;
    pim_otp_t otp_defaults = 32'hA55A3CC3;
    pim_reg_req_t reg_req;
    logic [7:0] reg_rdata;
    pim_event_t events = '0;
    pim_raw_t raw_in = '0;
    pim_flag_t flag_clr = '0;
    pim_raw_t raw_status;
    pim_flag_t flags;
    logic irq;
    logic [7:0] rdv;
    int mismatches = 0;
    int n_compared = 0;

    pim_host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_req(reg_req));
    pim_mask_bank dut (.clk_sys(clk_sys), .rst(rst), .otp_valid(otp_valid),
        .otp_defaults(otp_defaults), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .events(events), .raw_in(raw_in), .flag_clr(flag_clr), .raw_status(raw_status),
        .flags(flags), .irq(irq));

    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic clr_all();
        flag_clr = '1;
        @(posedge clk_sys) #1 flag_clr = '0;
    endtask
    task automatic do_reset(input logic ov);
        otp_valid = ov;
        rst = 1'b1;
        repeat (16) @(posedge clk_sys);
        #1 rst = 1'b0;
    endtask
    task automatic t_defaults(input logic [31:0] exp);
        for (int i = 0; i < 4; i++) begin
            host.rd(8'h29 + 8'(i), rdv);
            chk("mask reset", {2'b00, exp[31-8*i -: 8]}, {2'b00, rdv});
        end
    endtask
    task automatic t_rw();
        host.wr(8'h2D, 8'hFF);
        host.rd(8'h2D, rdv);
        chk("unmapped", 10'h000, {2'b00, rdv});
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h29 + 8'(i), 8'hFF);
            host.rd(8'h29 + 8'(i), rdv);
            chk("all bits", 10'h0FF, {2'b00, rdv});
        end
    endtask
    task automatic t_events();
        logic [19:0] e;
        for (int i = 0; i < 6; i++) begin
            e = EVT[i/2];
            host.wr(e[11:4], 8'(i % 2) << e[3:0]);
            events[e[19:16]] = 1'b1;
            @(posedge clk_sys) #1 events = '0;
            chk("event flag", 10'(1 - i % 2), {9'b0, flags[e[15:12]]});
            chk("irq", 10'(1 - i % 2), {9'b0, irq});
            clr_all();
        end
    endtask
    task automatic t_raw();
        logic [31:0] c;
        for (int i = 0; i < 28; i++) begin
            c = RAW[i];
            host.wr(c[23:16], c[15:8]);
            raw_in[c[31:28]] = c[4];
            // sync two edges, flag register one, plus one spare edge
            repeat (4) @(posedge clk_sys);
            #1;
            chk("raw status", {9'b0, c[4]}, {9'b0, raw_status[c[31:28]]});
            chk("raw flag", {9'b0, c[0]}, {9'b0, flags[c[27:24]]});
            clr_all();
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100us;
        mismatches++;
        complete_run();
    end
    initial begin
        do_reset(1'b0);
        t_defaults(32'h00010000);
        t_rw();
        t_events();
        t_raw();
        do_reset(1'b1);
        t_defaults(otp_defaults);
        complete_run();
    end
endmodule
